// ### cpd_host_model.sv
`timescale 1ns/1ps
// host side: frame requests, function control and power-down pin
module cpd_host_model
(
    input  wire logic sys_clk,
    input  wire logic frame_sync_n,
    input  wire logic powered_down,
    output logic      xfer_req,
    output logic      function_control_in,
    output logic      power_down_n
);
    // idle host, pin released high
    initial
    begin
        xfer_req = 1'b0;
        function_control_in = 1'b0;
        power_down_n = 1'b1;
    end
    // drive the power-down pin level
    task automatic set_power(input logic level);
        power_down_n = level;
    endtask : set_power
    // request one frame once the device is awake and idle
    task automatic frame(input logic fc, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++)
        begin
            @(negedge sys_clk);
            ok = !powered_down && frame_sync_n;
        end
        function_control_in = fc;
        xfer_req = ok;
        @(negedge sys_clk);
        xfer_req = 1'b0;
    endtask : frame
endmodule : cpd_host_model

// ### cpd_pkg.sv
package cpd_pkg;
    // width of the frame bit counter
    localparam int CPD_CNT_W      = 5;
    // bits shifted per frame
    localparam int CPD_FRAME_BITS = 16;
    // master clock cycles per serial bit
    localparam int CPD_BIT_DIV    = 4;
    // width of the bit divider counter
    localparam int CPD_DIV_W      = 3;
    // control register width and phone-mode flag field positions
    localparam int CPD_CTRL_W     = 8;
    localparam int CPD_FLAG0_POS  = 0;
    localparam int CPD_FLAG1_POS  = 1;
    // reset value of the retained control register
    localparam logic [7:0] CPD_CTRL_RST = 8'h00;

    // sequencer states
    typedef enum logic [1:0]
    {
        CPD_ST_IDLE  = 2'b00,
        CPD_ST_SHIFT = 2'b01,
        CPD_ST_DOWN  = 2'b10
    } cpd_state_t;
endpackage : cpd_pkg

// ### cpd_powerdown_ctrl.sv
`timescale 1ns/1ps
// How it works
// - low power-down stops port and clocks
// - control register keeps its value during power-down
// - resume with retained setup on release
// - power-down clears only internal counters
// - frame sync low marks active port
// - frame sync low while bits shift
// - phone mode drives flag from control
// - all timing derives from master clock
// - function control latched on sync rise
module cpd_powerdown_ctrl
#(
    parameter int FRAME_BITS = cpd_pkg::CPD_FRAME_BITS,
    parameter int BIT_DIV    = cpd_pkg::CPD_BIT_DIV
)
(
    input  wire logic                          sys_clk,
    input  wire logic                          reset_n,
    input  wire logic                          power_down_n,
    input  wire logic                          function_control_in,
    input  wire logic                          xfer_req,
    input  wire logic                          ctrl_wr,
    input  wire logic [cpd_pkg::CPD_CTRL_W-1:0] ctrl_wdata,
    input  wire logic                          phone_mode,
    output logic                               frame_sync_n,
    output logic                               serial_clk_en,
    output logic                               bit_strobe,
    output logic                               flag0_out,
    output logic                               flag1_out,
    output logic                               fc_latched,
    output logic                               powered_down
);
    import cpd_pkg::*;

    logic                 pd_n_sync;   // synchronised power-down pin
    logic                 fc_sync;     // synchronised function control
    cpd_state_t           state_reg;   // sequencer state
    cpd_state_t           state_next;
    logic [CPD_CNT_W-1:0] bit_cnt_reg; // bits shifted so far
    logic [CPD_DIV_W-1:0] div_reg;     // master clock divider
    logic [CPD_CTRL_W-1:0] ctrl_reg;   // retained control register
    logic                 bit_tick;    // one serial bit period elapsed
    logic                 last_bit;    // final bit of frame

    // pins cross into the clock domain first
    cpd_sync u_pd_sync
    (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .pin_in   (power_down_n),
        .pin_sync (pd_n_sync)
    );

    cpd_sync u_fc_sync
    (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .pin_in   (function_control_in),
        .pin_sync (fc_sync)
    );

    // bit timing from master clock only
    assign bit_tick = (div_reg == CPD_DIV_W'(BIT_DIV - 1));
    assign last_bit = bit_tick &&
                      (bit_cnt_reg == CPD_CNT_W'(FRAME_BITS - 1));

    // next state decode
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            CPD_ST_IDLE:
            begin
                if (!pd_n_sync)
                    state_next = CPD_ST_DOWN;
                else if (xfer_req)
                    state_next = CPD_ST_SHIFT;
            end
            CPD_ST_SHIFT:
            begin
                if (!pd_n_sync)
                    state_next = CPD_ST_DOWN;
                else if (last_bit)
                    state_next = CPD_ST_IDLE;
            end
            CPD_ST_DOWN:
            begin
                // resume straight to idle, no reprogramming
                if (pd_n_sync)
                    state_next = CPD_ST_IDLE;
            end
            default:
                state_next = CPD_ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_reg <= CPD_ST_IDLE;
        else
            state_reg <= state_next;
    end

    // clock divider, held cleared outside shifting
    // start edge also held so the first bit is full length
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            div_reg <= '0;
        else if (state_reg != CPD_ST_SHIFT || state_next != CPD_ST_SHIFT
                 || bit_tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + CPD_DIV_W'(1);
    end

    // bit counter, cleared by power-down
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            bit_cnt_reg <= '0;
        else if (state_next != CPD_ST_SHIFT)
            bit_cnt_reg <= '0;
        else if (bit_tick)
            bit_cnt_reg <= bit_cnt_reg + CPD_CNT_W'(1);
    end

    // control register: only software writes change it
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl_reg <= CPD_CTRL_RST;
        else if (ctrl_wr && state_reg != CPD_ST_DOWN)
            ctrl_reg <= ctrl_wdata;
    end

    // serial port outputs
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            frame_sync_n  <= 1'b1;
            serial_clk_en <= 1'b0;
            bit_strobe    <= 1'b0;
            powered_down  <= 1'b0;
        end
        else
        begin
            frame_sync_n  <= (state_next != CPD_ST_SHIFT);
            serial_clk_en <= (state_next != CPD_ST_DOWN);
            bit_strobe    <= (state_reg == CPD_ST_SHIFT) && bit_tick
                             && pd_n_sync;
            powered_down  <= (state_next == CPD_ST_DOWN);
        end
    end

    // function control caught on frame sync rising edge
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            fc_latched <= 1'b0;
        else if (!frame_sync_n && state_next != CPD_ST_SHIFT)
            fc_latched <= fc_sync;
    end

    // phone mode flag outputs
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag0_out <= 1'b0;
            flag1_out <= 1'b0;
        end
        else if (phone_mode)
        begin
            flag0_out <= ctrl_reg[CPD_FLAG0_POS];
            flag1_out <= ctrl_reg[CPD_FLAG1_POS];
        end
    end

    // frame sync and power-down are exclusive
    a_sync_down_excl: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        powered_down |-> frame_sync_n)
        else $error("frame sync active in power-down");

    a_ctrl_hold_down: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_reg == CPD_ST_DOWN) |=> $stable(ctrl_reg))
        else $error("control changed during power-down");

    a_resume_idle: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_reg == CPD_ST_DOWN && pd_n_sync)
        |=> state_reg == CPD_ST_IDLE)
        else $error("no resume after power-down release");

    a_count_clear: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_reg == CPD_ST_DOWN) |-> (bit_cnt_reg == '0 && div_reg == '0))
        else $error("counters not cleared in power-down");

    sequence s_start;
        state_reg == CPD_ST_IDLE && pd_n_sync && xfer_req;
    endsequence

    a_sync_start: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        s_start |=> !frame_sync_n)
        else $error("frame sync not driven low on start");

    a_sync_shift: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        bit_strobe |-> !$past(frame_sync_n))
        else $error("bit shifted with frame sync high");

    a_flag_phone: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        phone_mode |=> flag1_out == $past(ctrl_reg[CPD_FLAG1_POS])
                       && flag0_out == $past(ctrl_reg[CPD_FLAG0_POS]))
        else $error("flag does not follow control");

    a_fc_latch: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(frame_sync_n) |-> fc_latched == $past(fc_sync))
        else $error("function control not latched");
endmodule : cpd_powerdown_ctrl

// ### cpd_powerdown_ctrl_tb_top.sv
`timescale 1ns/1ps
// bench for the frame sequencer and power-down pin
module cpd_powerdown_ctrl_tb_top;
    import cpd_pkg::*;
    logic                  sys_clk, reset_n, ctrl_wr, phone_mode, ok;
    logic                  xfer_req, fc_in, pd_n, fs_n, clk_en, strobe;
    logic                  flag0, flag1, fc_q, pdown, prev_fs;
    logic [CPD_CTRL_W-1:0] ctrl_wdata, rnd;
    logic [31:0]           exp_q[$]; // expected frame results
    int                    n_mismatch, samples_checked, low_cnt, stb_cnt;
    // master clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    cpd_powerdown_ctrl i_cpd_powerdown_ctrl
    (
        .sys_clk(sys_clk), .reset_n(reset_n), .power_down_n(pd_n),
        .function_control_in(fc_in), .xfer_req(xfer_req),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .phone_mode(phone_mode), .frame_sync_n(fs_n),
        .serial_clk_en(clk_en), .bit_strobe(strobe), .flag0_out(flag0),
        .flag1_out(flag1), .fc_latched(fc_q), .powered_down(pdown)
    );
    cpd_host_model i_cpd_host_model
    (
        .sys_clk(sys_clk), .frame_sync_n(fs_n), .powered_down(pdown),
        .xfer_req(xfer_req), .function_control_in(fc_in),
        .power_down_n(pd_n)
    );
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    // pseudo-random control values
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // one-cycle control write, then settle
    task automatic wr(input logic [7:0] d);
        @(negedge sys_clk);
        ctrl_wr = 1'b1;
        ctrl_wdata = d;
        @(negedge sys_clk);
        ctrl_wr = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : wr
    // full frame: 64 low cycles, 16 strobes, latched fc
    task automatic run_frame(input logic fc);
        exp_q.push_back({7'h00, fc, 8'h10, 16'h0040});
        i_cpd_host_model.frame(fc, ok);
        if (!ok) n_mismatch++;
    endtask : run_frame
    // watcher: counts the frame, compares at release of sync
    always @(posedge sys_clk)
    begin
        #1;
        if (!fs_n) low_cnt++;
        if (strobe) stb_cnt++;
        if (fs_n && !prev_fs)
        begin
            if (!pdown && exp_q.size() > 0)
                check({7'h00, fc_q, stb_cnt[7:0], low_cnt[15:0]},
                      exp_q.pop_front());
            low_cnt = 0;
            stb_cnt = 0;
        end
        prev_fs = fs_n;
    end
    // hang guard
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        summarize();
    end
    // main sequence, inputs moved on falling edges
    initial
    begin
        {reset_n, ctrl_wr, ctrl_wdata, n_mismatch, samples_checked} = '0;
        {low_cnt, stb_cnt, phone_mode, prev_fs, rnd} = {64'h0, 2'h3, 8'h34};
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        check({flag1, flag0}, 32'h0);
        run_frame(1'b1);
        run_frame(1'b0);
        repeat (4)
        begin
            rnd = lfsr(rnd);
            wr(rnd);
            check({flag1, flag0}, rnd[1:0]);
        end
        phone_mode = 1'b0;
        wr(~rnd);
        check({flag1, flag0}, rnd[1:0]);
        phone_mode = 1'b1;
        repeat (2) @(negedge sys_clk);
        check({flag1, flag0}, {2'h0, ~rnd[1:0]});
        i_cpd_host_model.frame(1'b1, ok);
        if (!ok) n_mismatch++;
        repeat (10) @(negedge sys_clk);
        i_cpd_host_model.set_power(1'b0);
        repeat (5) @(negedge sys_clk);
        check({pdown, clk_en, fs_n}, 32'h5);
        wr(rnd);
        i_cpd_host_model.set_power(1'b1);
        repeat (5) @(negedge sys_clk);
        check({pdown, clk_en, flag1, flag0}, {2'h1, ~rnd[1:0]});
        run_frame(1'b1);
        for (int i = 0; i < 200 && exp_q.size() > 0; i++)
            @(negedge sys_clk);
        if (exp_q.size() > 0) n_mismatch++;
        summarize();
    end
endmodule : cpd_powerdown_ctrl_tb_top

// ### cpd_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs
module cpd_sync
(
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic pin_in,
    output logic      pin_sync
);
    logic meta_reg;    // first stage, read only by second stage

    // double flop; resets to zero
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_reg <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            meta_reg <= pin_in;
            pin_sync <= meta_reg;
        end
    end
endmodule : cpd_sync
